// >>> rtl/seq_step_pkg.sv
/*
   Shared constants for the converter sequencer step configuration bank:
   register addresses, field positions, reset values and input codes.
   Assumes a 16-bit register word behind an 8-bit register address.
*/
package seq_step_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // register addresses
   localparam logic [7:0] STEP14_ADDR = 8'h9E;
   localparam logic [7:0] STEP15_ADDR = 8'h9F;

   // reset values
   localparam logic [15:0] STEP14_RESET = 16'h000E;
   localparam logic [15:0] STEP15_RESET = 16'h000F;

   // field positions
   localparam int ENABLE_BIT = 15;
   localparam int GAIN_HI = 14;
   localparam int GAIN_LO = 13;
   localparam int RSVD_HI = 12;
   localparam int RSVD_LO = 5;
   localparam int NEG_BIT = 4;
   localparam int POS_HI = 3;
   localparam int POS_LO = 0;

   // writable bits: enable, gain, negative select, positive select
   localparam logic [15:0] WRITE_MASK = 16'hE01F;

   // gain codes and resulting factor
   localparam logic [1:0] GAIN_X1 = 2'h0;
   localparam logic [1:0] GAIN_X2 = 2'h1;
   localparam logic [2:0] FACTOR_1 = 3'h1;
   localparam logic [2:0] FACTOR_2 = 3'h2;
   localparam logic [2:0] FACTOR_4 = 3'h4;

   // positive input codes
   localparam logic [3:0] POS_INPUT_SEVEN = 4'h7;
   localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
   localparam logic [3:0] POS_SHORT_GND = 4'h9;
   localparam logic [3:0] POS_TEST_DAC = 4'hA;
   localparam logic [3:0] POS_ANALOG_SUPPLY_DIV4 = 4'hB;
   localparam logic [3:0] POS_IO_SUPPLY_DIV4 = 4'hC;
   localparam logic [3:0] POS_DIGITAL_SUPPLY_DIV2 = 4'hD;
   localparam logic [3:0] POS_ANALOG_POWER_DIV103 = 4'hE;
   localparam logic [3:0] POS_DIGITAL_POWER_DIV103 = 4'hF;

   // negative input routing
   localparam logic [1:0] NEG_ANALOG_GROUND = 2'h0;
   localparam logic [1:0] NEG_INPUT_SEVEN = 2'h1;
   localparam logic [1:0] NEG_AUTOMATIC = 2'h2;

endpackage

// >>> rtl/step_config_cell.sv
/*
   One step configuration register with its decoded selections.
   Assumes the parent delivers a one-cycle write strobe already decoded
   to this register's address.
*/
`timescale 1ns/1ps
`default_nettype none

module step_config_cell #(
   parameter logic [15:0] RESET_VALUE = 16'h0000
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // write access
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   // stored word and decoded fields
   output logic [15:0] word_reg,
   output logic enable_reg,
   output logic [2:0] gain_factor_reg,
   output logic [3:0] positive_input_reg,
   output logic [1:0] negative_route_reg,
   output logic internal_source_reg
);

   logic [15:0] word_next;
   logic [3:0] pos_next;
   logic internal_next;
   logic [2:0] factor_next;
   logic [1:0] route_next;

   // reserved bits are never stored, so they always read zero
   assign word_next = wr_en ? (wr_data & seq_step_pkg::WRITE_MASK) : word_reg;
   assign pos_next = word_next[seq_step_pkg::POS_HI:seq_step_pkg::POS_LO];
   // codes above input seven are internal sources
   assign internal_next = pos_next > seq_step_pkg::POS_INPUT_SEVEN;
   // 10b and 11b both mean gain 4
   assign factor_next =
      (word_next[seq_step_pkg::GAIN_HI:seq_step_pkg::GAIN_LO] == seq_step_pkg::GAIN_X1) ?
      seq_step_pkg::FACTOR_1 :
      (word_next[seq_step_pkg::GAIN_HI:seq_step_pkg::GAIN_LO] == seq_step_pkg::GAIN_X2) ?
      seq_step_pkg::FACTOR_2 : seq_step_pkg::FACTOR_4;
   // internal source overrides the negative select bit
   assign route_next = internal_next ? seq_step_pkg::NEG_AUTOMATIC :
      (word_next[seq_step_pkg::NEG_BIT] ? seq_step_pkg::NEG_INPUT_SEVEN :
      seq_step_pkg::NEG_ANALOG_GROUND);

   // word and decodes registered together so they never disagree
   always_ff @(posedge clk) begin
      if (!nrst) begin
         word_reg <= RESET_VALUE;
         enable_reg <= RESET_VALUE[seq_step_pkg::ENABLE_BIT];
         gain_factor_reg <= seq_step_pkg::FACTOR_1;
         positive_input_reg <= RESET_VALUE[3:0];
         negative_route_reg <= (RESET_VALUE[3:0] > seq_step_pkg::POS_INPUT_SEVEN) ?
            seq_step_pkg::NEG_AUTOMATIC : seq_step_pkg::NEG_ANALOG_GROUND;
         internal_source_reg <= RESET_VALUE[3:0] > seq_step_pkg::POS_INPUT_SEVEN;
      end else begin
         word_reg <= word_next;
         enable_reg <= word_next[seq_step_pkg::ENABLE_BIT];
         gain_factor_reg <= factor_next;
         positive_input_reg <= pos_next;
         negative_route_reg <= route_next;
         internal_source_reg <= internal_next;
      end
   end

endmodule

`default_nettype wire

// >>> rtl/mux_adc_sequence_step_config.sv
/*
   Step 14 and step 15 configuration registers of the multiplexed
   converter's channel sequencer, with registered decodes for the sequencer.
   Assumes a plain register port: one-cycle strobes, read data next cycle.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Bit 15 enables the step when 1 and disables it when 0, resetting disabled.
// - Bits 14:13 pick gain 1 for 00, gain 2 for 01 and gain 4 for 10 or 11.
// - Bits 12:5 are reserved and always read as zero whatever is written.
// - Bit 4 picks analog ground (0) or analog input seven (1) as negative input.
// - Bits 3:0 codes 0 to 7 pick external analog inputs zero to seven.
// - Code 8 is the temperature sensor, 9 a short to ground, 10 the test DAC.
// - Codes 11 to 15 are scaled supply monitors, power inputs /103 at 14 and 15.
// - For internal sources the negative input is automatic and bit 4 is ignored.
// - Step 14 positive code resets to 14; step 15 is at 9Fh and resets to 000Fh.
// - Step 14 register is at 9Eh and resets to 000Eh.
module mux_adc_sequence_step_config (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // step 14 selections toward the sequencer
   output logic step14_enable,
   output logic [2:0] step14_gain_factor,
   output logic [3:0] step14_positive_input_select,
   output logic [1:0] step14_negative_route,
   output logic step14_internal_source,
   // step 15 selections toward the sequencer
   output logic step15_enable,
   output logic [2:0] step15_gain_factor,
   output logic [3:0] step15_positive_input_select,
   output logic [1:0] step15_negative_route,
   output logic step15_internal_source,
   // sequencer request: which step is reached, and the verdict
   input wire logic step_arrive,
   input wire logic step_select_15,
   output logic step_convert_reg,
   output logic step_skip_reg
);

   logic [15:0] step14_word;
   logic [15:0] step15_word;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic hit14;
   logic hit15;
   logic wr14;
   logic wr15;
   logic target_enabled;

   // address decode; other addresses ignore writes and read zero
   assign hit14 = reg_addr == seq_step_pkg::STEP14_ADDR;
   assign hit15 = reg_addr == seq_step_pkg::STEP15_ADDR;
   assign wr14 = reg_wr & hit14;
   assign wr15 = reg_wr & hit15;

   // step 14 register, reset 000Eh
   step_config_cell #(
      .RESET_VALUE(seq_step_pkg::STEP14_RESET)
   ) step14_cell (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr14),
      .wr_data(reg_wdata),
      .word_reg(step14_word),
      .enable_reg(step14_enable),
      .gain_factor_reg(step14_gain_factor),
      .positive_input_reg(step14_positive_input_select),
      .negative_route_reg(step14_negative_route),
      .internal_source_reg(step14_internal_source)
   );

   // step 15 register, reset 000Fh
   step_config_cell #(
      .RESET_VALUE(seq_step_pkg::STEP15_RESET)
   ) step15_cell (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr15),
      .wr_data(reg_wdata),
      .word_reg(step15_word),
      .enable_reg(step15_enable),
      .gain_factor_reg(step15_gain_factor),
      .positive_input_reg(step15_positive_input_select),
      .negative_route_reg(step15_negative_route),
      .internal_source_reg(step15_internal_source)
   );

   // read mux; a read in the same cycle as a write returns the old word
   assign rdata_next = !reg_rd ? 16'h0000 :
      hit14 ? step14_word :
      hit15 ? step15_word : 16'h0000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata = rdata_reg;

   // skip verdict for a disabled step
   assign target_enabled = step_select_15 ? step15_enable : step14_enable;

   // one-cycle verdict pulses, one cycle after the arrival
   always_ff @(posedge clk) begin
      if (!nrst) begin
         step_convert_reg <= 1'b0;
         step_skip_reg <= 1'b0;
      end else begin
         step_convert_reg <= step_arrive & target_enabled;
         step_skip_reg <= step_arrive & ~target_enabled;
      end
   end

   // checks
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
      reg_rdata[12:5] == 8'h00)
      else $error("reserved bits read nonzero");

   AST_STEP14_RESET: assert property (@(posedge clk)
      $rose(nrst) |-> step14_word == 16'h000E && !step14_enable)
      else $error("step 14 reset value wrong");

   AST_STEP15_RESET: assert property (@(posedge clk)
      $rose(nrst) |-> step15_word == 16'h000F && step15_positive_input_select == 4'hF)
      else $error("step 15 reset value wrong");

   AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E |=> step14_enable == $past(reg_wdata[15]))
      else $error("step 14 enable did not follow write");

   AST_GAIN_DECODE: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F |=> step15_gain_factor ==
      ($past(reg_wdata[14:13]) == 2'h0 ? 3'h1 : $past(reg_wdata[14:13]) == 2'h1 ? 3'h2 : 3'h4))
      else $error("gain decode wrong");

   AST_NEG_SELECT: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E && reg_wdata[3:0] < 4'h8 |=>
      step14_negative_route == {1'b0, $past(reg_wdata[4])})
      else $error("negative select wrong");

   AST_POS_EXTERNAL: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F |=> step15_positive_input_select == $past(reg_wdata[3:0])
      && step15_internal_source == ($past(reg_wdata[3:0]) > 4'h7))
      else $error("positive select wrong");

   AST_INTERNAL_SRC: assert property (@(posedge clk) disable iff (!nrst)
      step14_positive_input_select inside {4'h8, 4'h9, 4'hA} |-> step14_internal_source)
      else $error("internal source flag missing");

   AST_SUPPLY_SRC: assert property (@(posedge clk) disable iff (!nrst)
      step15_positive_input_select >= 4'hB |-> step15_internal_source)
      else $error("supply monitor not internal");

   AST_NEG_AUTO: assert property (@(posedge clk) disable iff (!nrst)
      step14_internal_source |-> step14_negative_route == 2'h2)
      else $error("negative not automatic for internal source");

   AST_READBACK: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F ##1 reg_rd && reg_addr == 8'h9F && !reg_wr |=>
      reg_rdata == ($past(reg_wdata, 2) & 16'hE01F))
      else $error("step 15 readback wrong");

   AST_SKIP: assert property (@(posedge clk) disable iff (!nrst)
      step_arrive && !step_select_15 && !step14_enable |=> step_skip_reg && !step_convert_reg)
      else $error("disabled step not skipped");

   // second step and the paths the first group leaves open
   AST_STEP15_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F
      |=> step15_enable == $past(reg_wdata[15]))
      else $error("step 15 enable did not follow write");

   AST_STEP14_GAIN_DECODE: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E |=> step14_gain_factor ==
      ($past(reg_wdata[14:13]) == 2'h0 ? 3'h1 : $past(reg_wdata[14:13]) == 2'h1 ? 3'h2 : 3'h4))
      else $error("step 14 gain decode wrong");

   AST_STEP14_RSVD_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E
      |=> step14_word[12:5] == 8'h00)
      else $error("step 14 stored reserved bits");

   AST_STEP15_RSVD_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F
      |=> step15_word[12:5] == 8'h00)
      else $error("step 15 stored reserved bits");

   AST_STEP15_NEG_SELECT: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9F && reg_wdata[3:0] < 4'h8
      |=> step15_negative_route == {1'b0, $past(reg_wdata[4])})
      else $error("step 15 negative select wrong");

   AST_STEP14_POS_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E
      |=> step14_positive_input_select == $past(reg_wdata[3:0]))
      else $error("step 14 positive select wrong");

   AST_STEP14_EXTERNAL: assert property (@(posedge clk) disable iff (!nrst)
      step14_positive_input_select < 4'h8
      |-> !step14_internal_source && step14_negative_route == {1'b0, step14_word[4]})
      else $error("step 14 external input routed wrong");

   AST_STEP15_INTERNAL_SRC: assert property (@(posedge clk) disable iff (!nrst)
      step15_positive_input_select inside {4'h8, 4'h9, 4'hA}
      |-> step15_internal_source && step15_negative_route == 2'h2)
      else $error("step 15 internal source wrong");

   AST_STEP14_SUPPLY_SRC: assert property (@(posedge clk) disable iff (!nrst)
      step14_positive_input_select >= 4'hB
      |-> step14_internal_source && step14_negative_route == 2'h2)
      else $error("step 14 supply monitor wrong");

   AST_STEP15_NEG_AUTO: assert property (@(posedge clk) disable iff (!nrst)
      step15_internal_source
      |-> step15_negative_route == 2'h2)
      else $error("step 15 negative not automatic");

   AST_STEP14_READBACK: assert property (@(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h9E ##1 reg_rd && reg_addr == 8'h9E && !reg_wr
      |=> reg_rdata == ($past(reg_wdata, 2) & 16'hE01F))
      else $error("step 14 readback wrong");

   AST_STEP14_READ_WORD: assert property (@(posedge clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h9E
      |=> reg_rdata == $past(step14_word))
      else $error("step 14 read data wrong");

   AST_STEP15_SKIP: assert property (@(posedge clk) disable iff (!nrst)
      step_arrive && step_select_15 && !step15_enable
      |=> step_skip_reg && !step_convert_reg)
      else $error("disabled step 15 not skipped");

   AST_STEP14_CONVERT: assert property (@(posedge clk) disable iff (!nrst)
      step_arrive && !step_select_15 && step14_enable
      |=> step_convert_reg && !step_skip_reg)
      else $error("enabled step 14 not converted");

   AST_STEP15_CONVERT: assert property (@(posedge clk) disable iff (!nrst)
      step_arrive && step_select_15 && step15_enable
      |=> step_convert_reg && !step_skip_reg)
      else $error("enabled step 15 not converted");

   AST_NO_VERDICT: assert property (@(posedge clk) disable iff (!nrst)
      !step_arrive
      |=> !step_convert_reg && !step_skip_reg)
      else $error("verdict without arrival");

   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!nrst)
      !reg_rd
      |=> reg_rdata == 16'h0000)
      else $error("read data without read strobe");

   AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!nrst)
      reg_rd && reg_addr != 8'h9E && reg_addr != 8'h9F
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read nonzero");

   AST_STEP14_WRITE_GUARD: assert property (@(posedge clk) disable iff (!nrst)
      !(reg_wr && reg_addr == 8'h9E)
      |=> step14_word == $past(step14_word))
      else $error("step 14 changed without write");

   AST_STEP15_WRITE_GUARD: assert property (@(posedge clk) disable iff (!nrst)
      !(reg_wr && reg_addr == 8'h9F)
      |=> step15_word == $past(step15_word))
      else $error("step 15 changed without write");

   AST_STEP14_MIRROR: assert property (@(posedge clk) disable iff (!nrst)
      step14_enable == step14_word[15]
      && step14_positive_input_select == step14_word[3:0])
      else $error("step 14 outputs disagree with word");

   AST_STEP15_MIRROR: assert property (@(posedge clk) disable iff (!nrst)
      step15_enable == step15_word[15]
      && step15_positive_input_select == step15_word[3:0])
      else $error("step 15 outputs disagree with word");

   AST_STEP14_RESET_DECODE: assert property (@(posedge clk)
      $rose(nrst) |-> step14_gain_factor == 3'h1
      && step14_negative_route == 2'h2 && step14_internal_source)
      else $error("step 14 reset decode wrong");

   AST_STEP15_RESET_DECODE: assert property (@(posedge clk)
      $rose(nrst) |-> step15_gain_factor == 3'h1 && !step15_enable
      && step15_negative_route == 2'h2 && step15_internal_source)
      else $error("step 15 reset decode wrong");

endmodule

`default_nettype wire

// >>> verification/test_mux_adc_sequence_step_config.sv
/*
   Self-checking bench for the step 14 and step 15 configuration bank.
   Assumes the plain register port and sequencer handshake of the design,
   one-cycle strobes driven just after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module test_mux_adc_sequence_step_config;
   logic clk, nrst, reg_wr, reg_rd, step_arrive, step_select_15;
   logic [7:0] reg_addr, a;
   logic [15:0] reg_wdata, reg_rdata, w14, w15, d;
   logic [2:0] g14, g15;
   logic [3:0] p14, p15;
   logic [1:0] n14, n15;
   logic e14, e15, i14, i15, step_convert_reg, step_skip_reg, rd_d, ar_d;
   logic [31:0] rnd;
   logic [7:0] bad [4];
   logic [15:0] rd_q [$];
   logic [1:0] ar_q [$];
   int failures, num_checks;

   mux_adc_sequence_step_config mux_adc_sequence_step_config_inst (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .step14_enable(e14), .step14_gain_factor(g14), .step14_positive_input_select(p14),
      .step14_negative_route(n14), .step14_internal_source(i14),
      .step15_enable(e15), .step15_gain_factor(g15), .step15_positive_input_select(p15),
      .step15_negative_route(n15), .step15_internal_source(i15),
      .step_arrive(step_arrive), .step_select_15(step_select_15),
      .step_convert_reg(step_convert_reg), .step_skip_reg(step_skip_reg));

   // 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [2:0] fac(input logic [1:0] c);
      if (c == 2'h0) return seq_step_pkg::FACTOR_1;
      if (c == 2'h1) return seq_step_pkg::FACTOR_2;
      return seq_step_pkg::FACTOR_4; // both upper codes give gain 4
   endfunction

   task automatic chk_dec(input logic [15:0] w, input logic e, input logic [2:0] g,
         input logic [3:0] p, input logic [1:0] n, input logic i);
      logic [1:0] ne;
      ne = w[3] ? seq_step_pkg::NEG_AUTOMATIC :
         (w[4] ? seq_step_pkg::NEG_INPUT_SEVEN : seq_step_pkg::NEG_ANALOG_GROUND);
      check({15'h0, e}, {15'h0, w[15]}, "enable");
      check({13'h0, g}, {13'h0, fac(w[14:13])}, "gain");
      check({12'h0, p}, {12'h0, w[3:0]}, "positive");
      check({14'h0, n}, {14'h0, ne}, "neg");
      check({15'h0, i}, {15'h0, w[3]}, "internal");
   endtask

   // every task sets all strobes once, so back-to-back calls never double-assign
   task automatic drive(input logic wr, input logic rd, input logic ar, input logic [7:0] ad,
         input logic [15:0] dt, input logic s);
      reg_wr <= wr;
      reg_rd <= rd;
      step_arrive <= ar;
      reg_addr <= ad;
      reg_wdata <= dt;
      step_select_15 <= s;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
      drive(1'h1, 1'h0, 1'h0, ad, dt, 1'h0);
      if (ad == 8'h9E) w14 = dt & 16'hE01F;
      if (ad == 8'h9F) w15 = dt & 16'hE01F;
   endtask

   task automatic rd(input logic [7:0] ad);
      rd_q.push_back(ad == 8'h9E ? w14 : (ad == 8'h9F ? w15 : 16'h0000));
      drive(1'h0, 1'h1, 1'h0, ad, 16'($urandom), 1'h0);
   endtask

   task automatic arrive(input logic s);
      ar_q.push_back(s ? {w15[15], ~w15[15]} : {w14[15], ~w14[15]});
      drive(1'h0, 1'h0, 1'h1, 8'($urandom), 16'($urandom), s);
   endtask

   task automatic idle();
      drive(1'h0, 1'h0, 1'h0, 8'($urandom), 16'($urandom), 1'h0);
   endtask

   // one quiet cycle first, so a result still due is compared before reset hides it
   task automatic do_reset(input int n);
      idle();
      nrst <= 1'h0;
      repeat (n) @(posedge clk);
      nrst <= 1'h1;
      w14 = 16'h000E;
      w15 = 16'h000F;
      @(posedge clk);
   endtask

   task automatic chk_both();
      chk_dec(w14, e14, g14, p14, n14, i14);
      chk_dec(w15, e15, g15, p15, n15, i15);
   endtask

   // strobe history: a result is due one cycle after its request
   always @(posedge clk) begin
      rd_d <= reg_rd;
      ar_d <= step_arrive;
   end

   // watcher takes the oldest note whenever a result is due
   always @(negedge clk) begin
      if (nrst) begin
         if (rd_d) check(reg_rdata, rd_q.pop_front(), "read");
         else check(reg_rdata, 16'h0000, "idle read");
         if (ar_d) check({14'h0, step_convert_reg, step_skip_reg},
               {14'h0, ar_q.pop_front()}, "verdict");
         else check({14'h0, step_convert_reg, step_skip_reg}, 16'h0000, "no verdict");
      end
   end

   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // watchdog, far beyond the some 1070 cycles the tests need
   initial begin
      #200us;
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      {nrst, reg_wr, reg_rd, step_arrive, step_select_15, rd_d, ar_d} = 7'h00;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      failures = 0;
      num_checks = 0;
      bad = '{8'h9D, 8'hA0, 8'h1E, 8'h00};
      rnd = $urandom(32'hB626BADC);
      do_reset(16);
      rd(8'h9E);
      rd(8'h9F);
      arrive(1'h0);
      arrive(1'h1);
      idle();
      chk_both();
      $display("test reset_values done");
      // every positive code, negative bit and gain code on both steps
      for (int k = 0; k < 256; k++) begin
         rnd = $urandom;
         a = k[7] ? 8'h9F : 8'h9E;
         d = {rnd[0], k[6:5], rnd[8:1], k[4], k[3:0]};
         wr(a, d);
         rd(a);
         arrive(k[7]);
         idle();
         chk_both();
      end
      $display("test field_sweep done");
      // unmapped places take nothing and read zero
      for (int k = 0; k < 4; k++) begin
         wr(bad[k], 16'($urandom));
         rd(bad[k]);
      end
      rd(8'h9E);
      rd(8'h9F);
      idle();
      chk_both();
      $display("test unmapped done");
      // reset in mid-run restores both words
      wr(8'h9E, 16'hFFFF);
      wr(8'h9F, 16'hFFFF);
      arrive(1'h1);
      do_reset(3);
      rd(8'h9E);
      rd(8'h9F);
      arrive(1'h0);
      idle();
      chk_both();
      $display("test mid_reset done");
      idle();
      end_of_test();
   end
endmodule

`default_nettype wire
